// ### include/tmr_pkg.sv
// Package for the timer control block: register indices, resets, types.
// Assumes an AXI4-Lite master with 12-bit byte addresses and 32-bit data.
package tmr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_T01_CONTROL   = 8'h88;
	localparam logic [7:0]  IDX_T0_COUNT_LOW  = 8'h8A;
	localparam logic [7:0]  IDX_T1_COUNT_LOW  = 8'h8B;
	localparam logic [7:0]  IDX_T0_COUNT_HIGH = 8'h8C;
	localparam logic [7:0]  IDX_T1_COUNT_HIGH = 8'h8D;
	localparam logic [7:0]  IDX_T2_CONTROL    = 8'hC8;
	localparam logic [7:0]  IDX_T2_RELOAD_LOW = 8'hCA;
	localparam logic [7:0]  IDX_T2_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0]  IDX_T2_COUNT_LOW  = 8'hCC;
	localparam logic [7:0]  IDX_T2_COUNT_HIGH = 8'hCD;

	localparam int          ADDR_W            = 12;
	localparam int          IDX_LSB           = 2;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset and fixed values
	localparam logic [7:0]  RST_BYTE          = 8'h00;
	localparam logic [15:0] RST_COUNT         = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
	localparam logic [15:0] COUNT_STEP        = 16'h0001;
	localparam logic        PIN_IDLE          = 1'b1;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	localparam logic [23:0] READ_PAD          = 24'h000000;

	////////////////////////////////////////////////////////////////////////////
	// Control register layouts, bit 7 first
	typedef struct packed {
		logic t1_overflow_flag;
		logic t1_run;
		logic t0_overflow_flag;
		logic t0_run;
		logic ext_irq1_flag;
		logic ext_irq1_edge_select;
		logic ext_irq0_flag;
		logic ext_irq0_edge_select;
	} tmr_t01ctl_t;

	typedef struct packed {
		logic t2_overflow_flag;
		logic t2_external_flag;
		logic serial_rx_clock_from_t2;
		logic serial_tx_clock_from_t2;
		logic t2_external_enable;
		logic t2_run;
		logic t2_counter_select;
		logic t2_capture_select;
	} tmr_t2ctl_t;

	typedef enum logic {TMR_WR_COLLECT, TMR_WR_RESP} tmr_wr_state_t;
	typedef enum logic {TMR_RD_IDLE, TMR_RD_RESP} tmr_rd_state_t;

endpackage

// ### rtl/tmr_fall_detect.sv
// Falling-edge detector for one pin sampled on the core clock.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none

module tmr_fall_detect
	import tmr_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      last,
	output logic      fell
);

	// Idle-high reset value makes a pin that is low at release read as a falling edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			last <= PIN_IDLE;
		end else begin
			last <= pin;
		end
	end

	// High in one cycle, low in the next
	assign fell = last & ~pin;

endmodule

`default_nettype wire

// ### rtl/tmr_timer_control.sv
// Three 16-bit timer/counters with control flags and external irq flags.
// Assumes an AXI4-Lite master, synchronous pins and vector acknowledge pulses.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module tmr_timer_control
	import tmr_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RESETN,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              EXT_IRQ0_PIN,
	input  wire logic              EXT_IRQ1_PIN,
	input  wire logic              T2_COUNT_PIN,
	input  wire logic              T2_EXTERNAL_TRIGGER_PIN,
	input  wire logic              VEC_T0,
	input  wire logic              VEC_T1,
	input  wire logic              VEC_EXT0,
	input  wire logic              VEC_EXT1,
	input  wire logic              SERIAL_MODE_VARIABLE,
	output logic                   T0_OVERFLOW_FLAG,
	output logic                   T1_OVERFLOW_FLAG,
	output logic                   EXT_IRQ0_FLAG,
	output logic                   EXT_IRQ1_FLAG,
	output logic                   T2_OVERFLOW_FLAG,
	output logic                   T2_EXTERNAL_FLAG,
	output logic                   SERIAL_RX_CLOCK,
	output logic                   SERIAL_TX_CLOCK
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			IDX_T01_CONTROL, IDX_T0_COUNT_LOW, IDX_T1_COUNT_LOW,
			IDX_T0_COUNT_HIGH, IDX_T1_COUNT_HIGH, IDX_T2_CONTROL,
			IDX_T2_RELOAD_LOW, IDX_T2_RELOAD_HIGH, IDX_T2_COUNT_LOW,
			IDX_T2_COUNT_HIGH: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic addr_bad(input logic [ADDR_W-1:0] addr);
		addr_bad = (addr[ADDR_W-1:10] != 2'h0) || (addr[1:0] != 2'h0)
			|| !is_mapped(addr[9:IDX_LSB]);
	endfunction

	function automatic logic wr_to(input logic en, input logic [7:0] at,
		input logic [7:0] idx);
		wr_to = en && (at == idx);
	endfunction

	function automatic logic [15:0] bump(input logic [15:0] value);
		bump = value + COUNT_STEP;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	tmr_wr_state_t wr_state;
	tmr_rd_state_t rd_state;
	logic          aw_full;
	logic          w_full;
	logic [7:0]    aw_idx;
	logic          aw_bad;
	logic [7:0]    w_byte;
	logic          w_lane0;
	logic          wr_commit;
	logic          wr_en;
	logic [7:0]    rd_byte;
	logic [7:0]    rd_idx;

	tmr_t01ctl_t   ctl01;
	tmr_t2ctl_t    ctl2;
	logic [15:0]   cnt0;
	logic [15:0]   cnt1;
	logic [15:0]   cnt2;
	logic [15:0]   reload2;

	logic          irq0_fell;
	logic          irq1_fell;
	logic          t2c_fell;
	logic          t2x_fell;

	logic          t0_inc;
	logic          t0_ovf;
	logic          t1_inc;
	logic          t1_ovf;
	logic          baud;
	logic          t2_inc;
	logic          t2_ovf;
	logic          t2_ext;
	logic          t2_capture;
	logic          t2_reload;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order

	assign wr_commit = (wr_state == TMR_WR_COLLECT) && aw_full && w_full;
	// Only lane 0 carries register bits; other lanes alone write nothing
	assign wr_en     = wr_commit && !aw_bad && w_lane0;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			S_AXI_AWREADY <= 1'b1;
			aw_full       <= 1'b0;
			aw_idx        <= RST_BYTE;
			aw_bad        <= 1'b0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			S_AXI_AWREADY <= 1'b0;
			aw_full       <= 1'b1;
			aw_idx        <= S_AXI_AWADDR[9:IDX_LSB];
			aw_bad        <= addr_bad(S_AXI_AWADDR);
		end else if (wr_commit) begin
			aw_full <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			S_AXI_WREADY <= 1'b1;
			w_full       <= 1'b0;
			w_byte       <= RST_BYTE;
			w_lane0      <= 1'b0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			S_AXI_WREADY <= 1'b0;
			w_full       <= 1'b1;
			w_byte       <= S_AXI_WDATA[7:0];
			w_lane0      <= S_AXI_WSTRB[0];
		end else if (wr_commit) begin
			w_full <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			wr_state     <= TMR_WR_COLLECT;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else begin
			case (wr_state)
				TMR_WR_COLLECT: begin
					if (wr_commit) begin
						S_AXI_BVALID <= 1'b1;
						S_AXI_BRESP  <= aw_bad ? RESP_SLVERR : RESP_OKAY;
						wr_state     <= TMR_WR_RESP;
					end
				end
				TMR_WR_RESP: begin
					if (S_AXI_BREADY) begin
						S_AXI_BVALID <= 1'b0;
						wr_state     <= TMR_WR_COLLECT;
					end
				end
				default: wr_state <= TMR_WR_COLLECT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	assign rd_idx = S_AXI_ARADDR[9:IDX_LSB];

	always_comb begin
		case (rd_idx)
			IDX_T01_CONTROL:    rd_byte = ctl01;
			IDX_T0_COUNT_LOW:   rd_byte = cnt0[7:0];
			IDX_T1_COUNT_LOW:   rd_byte = cnt1[7:0];
			IDX_T0_COUNT_HIGH:  rd_byte = cnt0[15:8];
			IDX_T1_COUNT_HIGH:  rd_byte = cnt1[15:8];
			IDX_T2_CONTROL:     rd_byte = ctl2;
			IDX_T2_RELOAD_LOW:  rd_byte = reload2[7:0];
			IDX_T2_RELOAD_HIGH: rd_byte = reload2[15:8];
			IDX_T2_COUNT_LOW:   rd_byte = cnt2[7:0];
			IDX_T2_COUNT_HIGH:  rd_byte = cnt2[15:8];
			default:            rd_byte = RST_BYTE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			rd_state      <= TMR_RD_IDLE;
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= {READ_PAD, RST_BYTE};
			S_AXI_RRESP   <= RESP_OKAY;
		end else begin
			case (rd_state)
				TMR_RD_IDLE: begin
					if (S_AXI_ARVALID) begin
						S_AXI_ARREADY <= 1'b0;
						S_AXI_RVALID  <= 1'b1;
						S_AXI_RDATA   <= addr_bad(S_AXI_ARADDR) ?
							{READ_PAD, RST_BYTE} : {READ_PAD, rd_byte};
						S_AXI_RRESP   <= addr_bad(S_AXI_ARADDR) ?
							RESP_SLVERR : RESP_OKAY;
						rd_state      <= TMR_RD_RESP;
					end
				end
				TMR_RD_RESP: begin
					if (S_AXI_RREADY) begin
						S_AXI_RVALID  <= 1'b0;
						S_AXI_ARREADY <= 1'b1;
						rd_state      <= TMR_RD_IDLE;
					end
				end
				default: rd_state <= TMR_RD_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin edge detection

	tmr_fall_detect u_irq0 (.clk(CLK), .resetn(RESETN), .pin(EXT_IRQ0_PIN),
		.last(), .fell(irq0_fell));
	tmr_fall_detect u_irq1 (.clk(CLK), .resetn(RESETN), .pin(EXT_IRQ1_PIN),
		.last(), .fell(irq1_fell));
	tmr_fall_detect u_t2c (.clk(CLK), .resetn(RESETN), .pin(T2_COUNT_PIN),
		.last(), .fell(t2c_fell));
	tmr_fall_detect u_t2x (.clk(CLK), .resetn(RESETN),
		.pin(T2_EXTERNAL_TRIGGER_PIN), .last(), .fell(t2x_fell));

	////////////////////////////////////////////////////////////////////////////
	// Timer 0 and Timer 1: 16-bit, one step per cycle

	assign t0_inc = ctl01.t0_run;
	assign t1_inc = ctl01.t1_run;
	assign t0_ovf = t0_inc && (cnt0 == COUNT_MAX);
	assign t1_ovf = t1_inc && (cnt1 == COUNT_MAX);

	// Software byte writes win over the step in the same cycle
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt0 <= RST_COUNT;
		end else begin
			if (t0_inc) begin
				cnt0 <= bump(cnt0);
			end
			if (wr_to(wr_en, aw_idx, IDX_T0_COUNT_LOW)) begin
				cnt0[7:0] <= w_byte;
			end
			if (wr_to(wr_en, aw_idx, IDX_T0_COUNT_HIGH)) begin
				cnt0[15:8] <= w_byte;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt1 <= RST_COUNT;
		end else begin
			if (t1_inc) begin
				cnt1 <= bump(cnt1);
			end
			if (wr_to(wr_en, aw_idx, IDX_T1_COUNT_LOW)) begin
				cnt1[7:0] <= w_byte;
			end
			if (wr_to(wr_en, aw_idx, IDX_T1_COUNT_HIGH)) begin
				cnt1[15:8] <= w_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer 0/1 control; the irq bits feed only the flag logic below

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ctl01 <= tmr_t01ctl_t'(RST_BYTE);
		end else begin
			if (wr_to(wr_en, aw_idx, IDX_T01_CONTROL)) begin
				ctl01 <= tmr_t01ctl_t'(w_byte);
			end
			if (VEC_T0) begin
				ctl01.t0_overflow_flag <= 1'b0;
			end
			if (t0_ovf) begin
				ctl01.t0_overflow_flag <= 1'b1;
			end
			if (VEC_T1) begin
				ctl01.t1_overflow_flag <= 1'b0;
			end
			if (t1_ovf) begin
				ctl01.t1_overflow_flag <= 1'b1;
			end
			// Level mode: the pin owns the flag, vector and writes have no say
			if (!ctl01.ext_irq0_edge_select) begin
				ctl01.ext_irq0_flag <= ~EXT_IRQ0_PIN;
			end else begin
				if (VEC_EXT0) begin
					ctl01.ext_irq0_flag <= 1'b0;
				end
				if (irq0_fell) begin
					ctl01.ext_irq0_flag <= 1'b1;
				end
			end
			if (!ctl01.ext_irq1_edge_select) begin
				ctl01.ext_irq1_flag <= ~EXT_IRQ1_PIN;
			end else begin
				if (VEC_EXT1) begin
					ctl01.ext_irq1_flag <= 1'b0;
				end
				if (irq1_fell) begin
					ctl01.ext_irq1_flag <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer 2

	assign baud       = ctl2.serial_rx_clock_from_t2 | ctl2.serial_tx_clock_from_t2;
	assign t2_inc     = ctl2.t2_run && (ctl2.t2_counter_select ? t2c_fell : 1'b1);
	assign t2_ovf     = t2_inc && (cnt2 == COUNT_MAX);
	assign t2_ext     = ctl2.t2_external_enable && t2x_fell && !baud;
	assign t2_capture = t2_ext && ctl2.t2_capture_select;
	assign t2_reload  = (t2_ovf && (baud || !ctl2.t2_capture_select))
		|| (t2_ext && !ctl2.t2_capture_select);

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt2 <= RST_COUNT;
		end else begin
			if (t2_reload) begin
				cnt2 <= reload2;
			end else if (t2_inc) begin
				cnt2 <= bump(cnt2);
			end
			if (wr_to(wr_en, aw_idx, IDX_T2_COUNT_LOW)) begin
				cnt2[7:0] <= w_byte;
			end
			if (wr_to(wr_en, aw_idx, IDX_T2_COUNT_HIGH)) begin
				cnt2[15:8] <= w_byte;
			end
		end
	end

	// A capture beats a same-cycle software write so the event is kept
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			reload2 <= RST_COUNT;
		end else begin
			if (wr_to(wr_en, aw_idx, IDX_T2_RELOAD_LOW)) begin
				reload2[7:0] <= w_byte;
			end
			if (wr_to(wr_en, aw_idx, IDX_T2_RELOAD_HIGH)) begin
				reload2[15:8] <= w_byte;
			end
			if (t2_capture) begin
				reload2 <= cnt2;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ctl2 <= tmr_t2ctl_t'(RST_BYTE);
		end else begin
			if (wr_to(wr_en, aw_idx, IDX_T2_CONTROL)) begin
				ctl2 <= tmr_t2ctl_t'(w_byte);
			end
			if (t2_ovf && !baud) begin
				ctl2.t2_overflow_flag <= 1'b1;
			end
			if (t2_ext) begin
				ctl2.t2_external_flag <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial port clock pulses and flag outputs

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			SERIAL_RX_CLOCK <= 1'b0;
			SERIAL_TX_CLOCK <= 1'b0;
		end else begin
			SERIAL_RX_CLOCK <= SERIAL_MODE_VARIABLE
				&& (ctl2.serial_rx_clock_from_t2 ? t2_ovf : t1_ovf);
			SERIAL_TX_CLOCK <= SERIAL_MODE_VARIABLE
				&& (ctl2.serial_tx_clock_from_t2 ? t2_ovf : t1_ovf);
		end
	end

	assign T0_OVERFLOW_FLAG = ctl01.t0_overflow_flag;
	assign T1_OVERFLOW_FLAG = ctl01.t1_overflow_flag;
	assign EXT_IRQ0_FLAG    = ctl01.ext_irq0_flag;
	assign EXT_IRQ1_FLAG    = ctl01.ext_irq1_flag;
	assign T2_OVERFLOW_FLAG = ctl2.t2_overflow_flag;
	assign T2_EXTERNAL_FLAG = ctl2.t2_external_flag;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_t0_ovf;
		t0_ovf |=> T0_OVERFLOW_FLAG;
	endproperty
	a_t0_ovf: assert property (p_t0_ovf) else $error("t0 overflow lost");

	property p_t1_ovf;
		t1_ovf |=> T1_OVERFLOW_FLAG;
	endproperty
	a_t1_ovf: assert property (p_t1_ovf) else $error("t1 overflow lost");

	property p_t0_hold;
		!ctl01.t0_run && !wr_en |=> $stable(cnt0);
	endproperty
	a_t0_hold: assert property (p_t0_hold) else $error("t0 moved while stopped");

	property p_level_follow;
		!ctl01.ext_irq0_edge_select |=> EXT_IRQ0_FLAG == !$past(EXT_IRQ0_PIN);
	endproperty
	a_level_follow: assert property (p_level_follow) else $error("level flag off");

	property p_edge_vec;
		ctl01.ext_irq0_edge_select && VEC_EXT0 && !irq0_fell
			&& !wr_to(wr_en, aw_idx, IDX_T01_CONTROL) |=> !EXT_IRQ0_FLAG;
	endproperty
	a_edge_vec: assert property (p_edge_vec) else $error("edge flag kept");

	property p_no_tf2_baud;
		baud && !wr_to(wr_en, aw_idx, IDX_T2_CONTROL) |=> !$rose(T2_OVERFLOW_FLAG);
	endproperty
	a_no_tf2_baud: assert property (p_no_tf2_baud) else $error("tf2 in baud mode");

	property p_exen_off;
		!ctl2.t2_external_enable && !wr_to(wr_en, aw_idx, IDX_T2_CONTROL)
			&& !wr_to(wr_en, aw_idx, IDX_T2_RELOAD_LOW)
			&& !wr_to(wr_en, aw_idx, IDX_T2_RELOAD_HIGH)
			|=> !$rose(T2_EXTERNAL_FLAG) && $stable(reload2) [*1];
	endproperty
	a_exen_off: assert property (p_exen_off) else $error("t2 trigger not ignored");

	property p_capture;
		t2_capture |=> reload2 == $past(cnt2);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_rx_clock;
		SERIAL_MODE_VARIABLE && ctl2.serial_rx_clock_from_t2 && t2_ovf ##1 1'b1
			|-> SERIAL_RX_CLOCK;
	endproperty
	a_rx_clock: assert property (p_rx_clock) else $error("rx clock missing");

endmodule

`default_nettype wire

// ### dv/tmr_core_model.sv
// Model of the core side: answers raised flags with vector pulses.
// Assumes flags are levels from the timer block on the same clock.
`timescale 1ns/10ps
`default_nettype none

module tmr_core_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [3:0] dly,
	input  wire logic [3:0] flag,
	output logic      [3:0] vec
);
	// Order of flags and vectors: t0, t1, ext0, ext1
	logic [3:0] busy;
	logic [3:0] cnt [4];

	////////////////////////////////////////////////////////////////////////////
	// One vector per raised flag; slow answers come from a large dly
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			vec[i] <= 1'b0;
			if (!resetn) begin
				busy[i] <= 1'b0;
			end else if (flag[i] && !busy[i]) begin
				busy[i] <= 1'b1;
				cnt[i] <= dly;
			end else if (!flag[i]) begin
				busy[i] <= 1'b0;
			end else if (cnt[i] == 4'h0) begin
				// Single pulse: a level request is not re-vectored while held
				vec[i] <= 1'b1;
				cnt[i] <= 4'hF;
			end else if (cnt[i] != 4'hF) begin
				cnt[i] <= cnt[i] - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/tmr_timer_control_tb.sv
// Self-checking bench for the timer control block over AXI4-Lite.
// Assumes the package and the core model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tmr_timer_control_tb
	import tmr_pkg::*;
;
	logic        clk, rstn, awv, wv, bry, arv, rry, smv, pc, pt;
	logic [1:0]  xp, bq, rq;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [3:0]  ws, vec, mdly;
	logic        awr, wr, bv, arr, rv;
	logic [7:0]  rl, rh;
	logic [15:0] c;
	wire  [7:0]  obs;
	int          err_total, n_tests, n;
	logic [1:0]  qb[$];
	logic [33:0] qr[$];
	logic [7:0]  regs[10] = '{IDX_T01_CONTROL, IDX_T0_COUNT_LOW, IDX_T1_COUNT_LOW,
		IDX_T0_COUNT_HIGH, IDX_T1_COUNT_HIGH, IDX_T2_CONTROL, IDX_T2_RELOAD_LOW,
		IDX_T2_RELOAD_HIGH, IDX_T2_COUNT_LOW, IDX_T2_COUNT_HIGH};

	tmr_timer_control i_dut (
		.CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bq), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rq), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.EXT_IRQ0_PIN(xp[0]), .EXT_IRQ1_PIN(xp[1]), .T2_COUNT_PIN(pc),
		.T2_EXTERNAL_TRIGGER_PIN(pt), .VEC_T0(vec[0]), .VEC_T1(vec[1]),
		.VEC_EXT0(vec[2]), .VEC_EXT1(vec[3]), .SERIAL_MODE_VARIABLE(smv),
		.T0_OVERFLOW_FLAG(obs[0]), .T1_OVERFLOW_FLAG(obs[1]), .EXT_IRQ0_FLAG(obs[2]),
		.EXT_IRQ1_FLAG(obs[3]), .T2_OVERFLOW_FLAG(obs[4]), .T2_EXTERNAL_FLAG(obs[5]),
		.SERIAL_RX_CLOCK(obs[6]), .SERIAL_TX_CLOCK(obs[7]));

	tmr_core_model i_core (.clk(clk), .resetn(rstn), .dly(mdly), .flag(obs[3:0]), .vec(vec));

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t bus exp %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_pin(input int b, input logic e);
		n_tests++;
		if (obs[b] !== e) begin
			err_total++;
			$display("[FAIL] %0t output %0d exp %b", $time, b, e);
		end
	endtask

	// Monitor: oldest note against each response as it is taken
	always @(posedge clk) begin
		if (bv === 1'b1 && bry === 1'b1) cmp_bus({32'h0, qb.pop_front()}, {32'h0, bq});
		if (rv === 1'b1 && rry === 1'b1) cmp_bus(qr.pop_front(), {rq, rdat});
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wx(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge clk);
		qb.push_back(r);
		awa <= a;
		wd <= {READ_PAD, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		bry <= 1'b0;
	endtask

	task automatic rx(input logic [11:0] a, input logic [33:0] e);
		@(posedge clk);
		qr.push_back(e);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rry <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] i, input logic [7:0] d);
		wx({2'b00, i, 2'b00}, d, RESP_OKAY);
	endtask

	task automatic rreg(input logic [7:0] i, input logic [7:0] d);
		rx({2'b00, i, 2'b00}, {RESP_OKAY, READ_PAD, d});
	endtask

	// Bounded wait on an output, checked at the falling edge
	task automatic wt(input int b, input logic v, input int lim);
		for (int k = 0; k < lim && obs[b] !== v; k++) @(negedge clk);
	endtask

	task automatic trig;
		@(posedge clk);
		pt <= 1'b0;
		@(posedge clk);
		pt <= 1'b1;
	endtask

	task automatic tdone(input string s);
		$display("test %s ended, mismatches %0d", s, err_total);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog at 20000 cycles, far beyond the several hundred cycles the tests need
	initial begin
		#400000;
		err_total++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{awv, wv, bry, arv, rry, rstn, err_total, n_tests} = '0;
		{xp, pc, pt, smv} = 5'h1F;
		{awa, ara, wd} = '0;
		ws = 4'h1;
		mdly = 4'h2;
		void'($urandom(40));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		foreach (regs[i]) rreg(regs[i], RST_BYTE);
		rx(12'h224, {RESP_SLVERR, 32'h0});
		wx(12'h224, 8'h5A, RESP_SLVERR);
		// Lane 0 strobe low: answered OKAY but nothing lands
		ws <= 4'hE;
		wreg(IDX_T2_RELOAD_LOW, 8'h5A);
		ws <= 4'h1;
		rreg(IDX_T2_RELOAD_LOW, RST_BYTE);
		tdone("reset");
		// Third pass repeats Timer 1 with the serial port in a fixed-rate mode
		for (int t = 0; t < 3; t++) begin
			n = int'(t > 0);
			smv <= (t < 2);
			mdly <= 4'($urandom_range(9, 3));
			wreg(n ? IDX_T1_COUNT_HIGH : IDX_T0_COUNT_HIGH, 8'hFF);
			wreg(n ? IDX_T1_COUNT_LOW : IDX_T0_COUNT_LOW, 8'hF8);
			wreg(IDX_T01_CONTROL, n ? 8'h40 : 8'h10);
			wt(n, 1'b1, 20);
			cmp_pin(n, 1'b1);
			cmp_pin(7, t == 1);
			cmp_pin(6, t == 1);
			wt(n, 1'b0, 20);
			cmp_pin(n, 1'b0);
			wreg(IDX_T01_CONTROL, 8'h00);
		end
		smv <= 1'b1;
		tdone("timers 0 and 1");
		for (int e = 0; e < 2; e++) begin
			wreg(IDX_T01_CONTROL, e ? 8'h04 : 8'h01);
			@(posedge clk);
			xp[e] <= 1'b0;
			wt(2 + e, 1'b1, 4);
			cmp_pin(2 + e, 1'b1);
			wt(2 + e, 1'b0, 20);
			cmp_pin(2 + e, 1'b0);
			wreg(IDX_T01_CONTROL, 8'h00);
			wt(2 + e, 1'b1, 4);
			cmp_pin(2 + e, 1'b1);
			repeat (20) @(negedge clk);
			cmp_pin(2 + e, 1'b1);
			@(posedge clk);
			xp[e] <= 1'b1;
			wt(2 + e, 1'b0, 4);
			cmp_pin(2 + e, 1'b0);
		end
		tdone("external irq");
		rl = 8'($urandom_range(127));
		rh = 8'($urandom);
		wreg(IDX_T2_RELOAD_LOW, rl);
		wreg(IDX_T2_RELOAD_HIGH, rh);
		wreg(IDX_T2_COUNT_HIGH, 8'hFF);
		wreg(IDX_T2_COUNT_LOW, 8'hF0);
		wreg(IDX_T2_CONTROL, 8'h04);
		wt(4, 1'b1, 40);
		cmp_pin(4, 1'b1);
		wreg(IDX_T2_CONTROL, 8'h80);
		rreg(IDX_T2_COUNT_HIGH, rh);
		cmp_pin(4, 1'b1);
		wreg(IDX_T2_CONTROL, 8'h00);
		cmp_pin(4, 1'b0);
		tdone("timer 2 reload");
		c = 16'($urandom);
		wreg(IDX_T2_COUNT_LOW, c[7:0]);
		wreg(IDX_T2_COUNT_HIGH, c[15:8]);
		wreg(IDX_T2_CONTROL, 8'h01);
		trig();
		rreg(IDX_T2_RELOAD_LOW, rl);
		cmp_pin(5, 1'b0);
		wreg(IDX_T2_CONTROL, 8'h09);
		trig();
		wt(5, 1'b1, 4);
		cmp_pin(5, 1'b1);
		rreg(IDX_T2_RELOAD_LOW, c[7:0]);
		rreg(IDX_T2_RELOAD_HIGH, c[15:8]);
		wreg(IDX_T2_COUNT_LOW, ~c[7:0]);
		wreg(IDX_T2_CONTROL, 8'h08);
		trig();
		rreg(IDX_T2_COUNT_LOW, c[7:0]);
		tdone("timer 2 capture");
		wreg(IDX_T2_RELOAD_LOW, rl);
		wreg(IDX_T2_RELOAD_HIGH, rh);
		wreg(IDX_T2_COUNT_HIGH, 8'hFF);
		wreg(IDX_T2_CONTROL, 8'h35);
		wt(6, 1'b1, 300);
		cmp_pin(6, 1'b1);
		cmp_pin(7, 1'b1);
		cmp_pin(4, 1'b0);
		wreg(IDX_T2_CONTROL, 8'h30);
		rreg(IDX_T2_COUNT_HIGH, rh);
		tdone("serial clock");
		n = $urandom_range(9, 3);
		wreg(IDX_T2_COUNT_LOW, 8'h00);
		wreg(IDX_T2_CONTROL, 8'h06);
		repeat (n) begin
			@(posedge clk);
			pc <= 1'b0;
			@(posedge clk);
			pc <= 1'b1;
		end
		wreg(IDX_T2_CONTROL, 8'h00);
		rreg(IDX_T2_COUNT_LOW, 8'(n));
		tdone("counter");
		final_report();
	end
endmodule
`default_nettype wire
